// [src/asr_pkg.sv]
package asr_pkg;

  // Register word offsets (byte addresses, Avalon word-aligned)
  localparam logic [4:0] ADDR_CTRL    = 5'h00;
  localparam logic [4:0] ADDR_STATUS  = 5'h04;
  localparam logic [4:0] ADDR_DATA    = 5'h08;
  localparam logic [4:0] ADDR_DIV_LO  = 5'h0c;
  localparam logic [4:0] ADDR_DIV_HI  = 5'h10;
  localparam logic [4:0] ADDR_IRQ_ST  = 5'h14;
  localparam logic [4:0] ADDR_IRQ_MSK = 5'h18;
  localparam logic [4:0] ADDR_ICTRL   = 5'h1c;

  // Control register bit positions
  localparam int CTRL_PORT_EN   = 7;
  localparam int CTRL_NINTH_EN  = 6;
  localparam int CTRL_CLOCKED   = 5;
  localparam int CTRL_CONT_EN   = 4;
  localparam int CTRL_ADDR_DET  = 3;
  localparam int CTRL_HISPEED   = 2;
  localparam int CTRL_WIDE_DIV  = 1;
  localparam int CTRL_IRQ_EN    = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register bit positions
  localparam int STAT_FRAMING   = 2;
  localparam int STAT_OVERRUN   = 1;
  localparam int STAT_NINTH     = 0;

  // Interrupt control bits
  localparam int ICTRL_GLOBAL   = 7;
  localparam int ICTRL_PERIPH   = 6;
  localparam int ICTRL_PRIO     = 0;

  // Sticky event bits
  localparam int EV_RX_DONE     = 0;
  localparam int EV_FRAMING     = 1;
  localparam int EV_OVERRUN     = 2;
  localparam int EV_W           = 3;

  localparam logic [15:0] DIV_RESET   = 16'h0000;
  localparam logic [3:0]  OVERSAMPLE  = 4'hf;
  localparam logic [3:0]  MID_SAMPLE  = 4'h7;

  typedef struct packed {
    logic        port_en;
    logic        ninth_en;
    logic        clocked;
    logic        cont_en;
    logic        addr_det;
    logic        hispeed;
    logic        wide_div;
    logic        irq_en;
  } asr_ctrl_s;

  typedef struct packed {
    logic [8:0]  data;
    logic        framing;
  } asr_frame_s;

endpackage

// [src/asr_tick_gen.sv]
`timescale 1ns/1ps
module asr_tick_gen
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic [15:0] divisor,
  input  wire logic        hispeed,
  input  wire logic        wide_div,
  output logic             tick
);
  // Counts per tick: 4*(divisor[7:0]+1) by default, divisor[7:0]+1 with hispeed alone, divisor+1 with wide_div, (divisor>>2)+1 with both; tick is 16x baud
  logic [17:0] cnt;
  logic [17:0] next_cnt;
  logic [17:0] limit;
  logic        next_tick;

  always_comb
  begin
    unique case ({wide_div, hispeed})
      2'b00:   limit = {2'b00, 8'h00, divisor[7:0]} * 18'h4 + 18'h3;
      2'b01:   limit = {2'b00, 8'h00, divisor[7:0]};
      2'b10:   limit = {2'b00, divisor} + 18'h0;
      default: limit = {2'b00, divisor} >> 2;
    endcase
    next_tick = 1'b0;
    next_cnt  = cnt + 18'h1;
    if (!run)
    begin
      next_cnt = 18'h0;
    end
    else if (cnt >= limit)
    begin
      next_cnt  = 18'h0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt  <= 18'h0;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// [src/asr_receiver.sv]
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module asr_receiver
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        serial_receive_pin,
  output logic             irq_high,
  output logic             irq_low
);
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} asr_state_e;

  asr_pkg::asr_ctrl_s ctrl, next_ctrl;
  logic [15:0]        div, next_div;
  logic [7:0]         ictrl, next_ictrl;
  logic [2:0]         ev, next_ev;
  logic [2:0]         msk, next_msk;
  asr_pkg::asr_frame_s buf_q, next_buf;
  logic               buf_full, next_buf_full;
  logic               ferr, next_ferr;
  logic               oerr, next_oerr;
  logic [31:0]        next_rdata;
  logic               ack, next_ack;

  asr_state_e         st, next_st;
  logic [3:0]         sub, next_sub;
  logic [3:0]         bitn, next_bitn;
  logic [8:0]         shf, next_shf;
  logic               tick;
  logic               rx_on;
  logic               done;
  logic               load;
  logic [3:0]         nbits;
  logic               any_ev;
  logic               acc;
  logic               pop;

  // Port usable only in asynchronous mode
  // enable gating
  assign rx_on = ctrl.port_en && !ctrl.clocked;
  assign nbits = ctrl.ninth_en ? 4'h9 : 4'h8;
  // Access completes at the edge where waitrequest is low
  assign acc   = (avs_read || avs_write) && ack;
  assign pop   = acc && avs_read && (avs_address == asr_pkg::ADDR_DATA);

  asr_tick_gen u_tick
  (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .run      (rx_on),
    .divisor  (div),
    .hispeed  (ctrl.hispeed),
    .wide_div (ctrl.wide_div),
    .tick     (tick)
  );

  // Receive state machine
  always_comb
  begin
    next_st   = st;
    next_sub  = sub;
    next_bitn = bitn;
    next_shf  = shf;
    done      = 1'b0;
    if (!rx_on || !ctrl.cont_en)
    begin
      next_st = ST_IDLE;
    end
    else if (tick)
    begin
      next_sub = sub + 4'h1;
      unique case (st)
        ST_IDLE:
        begin
          next_sub = 4'h0;
          if (!serial_receive_pin)
          begin
            next_st = ST_START;
          end
        end
        ST_START:
        begin
          // Glitch rejection at mid start bit
          if (sub == asr_pkg::MID_SAMPLE)
          begin
            next_sub = 4'h0;
            next_bitn = 4'h0;
            next_st = serial_receive_pin ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (sub == asr_pkg::OVERSAMPLE)
          begin
            next_shf = {serial_receive_pin, shf[8:1]};
            next_bitn = bitn + 4'h1;
            if (bitn + 4'h1 == nbits)
            begin
              next_st = ST_STOP;
            end
          end
        end
        ST_STOP:
        begin
          if (sub == asr_pkg::OVERSAMPLE)
          begin
            next_st = ST_IDLE;
            done = 1'b1;
          end
        end
      endcase
    end
  end

  assign load = done && !(ctrl.ninth_en && ctrl.addr_det &&
                          !(ctrl.ninth_en ? shf[8] : 1'b0));

  // Register and status next values
  always_comb
  begin
    next_ctrl     = ctrl;
    next_div      = div;
    next_ictrl    = ictrl;
    next_msk      = msk;
    next_ev       = ev;
    next_buf      = buf_q;
    next_buf_full = buf_full;
    next_ferr     = ferr;
    next_oerr     = oerr;
    next_rdata    = 32'h0;
    next_ack      = 1'b0;
    if ((avs_read || avs_write) && !ack)
    begin
      // Read data registered in the wait cycle, stands at the accepting edge
      next_ack = 1'b1;
      if (avs_read)
      begin
        unique case (avs_address)
          asr_pkg::ADDR_CTRL:    next_rdata = {24'h0, ctrl};
          asr_pkg::ADDR_STATUS:  next_rdata = {29'h0, ferr, oerr, buf_q.data[8]};
          asr_pkg::ADDR_DATA:    next_rdata = {24'h0, buf_q.data[7:0]};
          asr_pkg::ADDR_DIV_LO:  next_rdata = {24'h0, div[7:0]};
          asr_pkg::ADDR_DIV_HI:  next_rdata = {24'h0, div[15:8]};
          asr_pkg::ADDR_IRQ_ST:  next_rdata = {29'h0, ev};
          asr_pkg::ADDR_IRQ_MSK: next_rdata = {29'h0, msk};
          asr_pkg::ADDR_ICTRL:   next_rdata = {24'h0, ictrl};
          default:               next_rdata = 32'h0;
        endcase
      end
    end
    // Side effects only at the accepting edge, never while waitrequest is high
    if (acc && avs_write)
    begin
      unique case (avs_address)
        asr_pkg::ADDR_CTRL:    next_ctrl  = asr_pkg::asr_ctrl_s'(avs_writedata[7:0]);
        asr_pkg::ADDR_DIV_LO:  next_div[7:0] = avs_writedata[7:0];
        asr_pkg::ADDR_DIV_HI:  next_div[15:8] = avs_writedata[7:0];
        asr_pkg::ADDR_IRQ_ST:  next_ev = ev & ~avs_writedata[2:0];
        asr_pkg::ADDR_IRQ_MSK: next_msk = avs_writedata[2:0];
        asr_pkg::ADDR_ICTRL:   next_ictrl = avs_writedata[7:0];
        default:               next_ctrl = ctrl;
      endcase
    end
    if (pop)
    begin
      next_buf_full = 1'b0;
    end
    if (!next_ctrl.cont_en)
    begin
      next_ferr = 1'b0;
      next_oerr = 1'b0;
    end
    // Set wins over clear for every event
    if (load)
    begin
      // A pop in the same cycle frees room for the new frame
      if (buf_full && !pop)
      begin
        next_oerr = 1'b1;
        next_ev[asr_pkg::EV_OVERRUN] = 1'b1;
      end
      else
      begin
        next_buf.data = ctrl.ninth_en ? shf : {1'b0, shf[8:1]};
        next_buf.framing = !serial_receive_pin;
        next_buf_full = 1'b1;
        next_ev[asr_pkg::EV_RX_DONE] = 1'b1;
        if (!serial_receive_pin)
        begin
          next_ferr = 1'b1;
          next_ev[asr_pkg::EV_FRAMING] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st        <= ST_IDLE;
      sub       <= 4'h0;
      bitn      <= 4'h0;
      shf       <= 9'h0;
      ctrl      <= asr_pkg::CTRL_RESET;
      div       <= asr_pkg::DIV_RESET;
      ictrl     <= 8'h00;
      msk       <= 3'h0;
      ev        <= 3'h0;
      buf_q     <= '0;
      buf_full  <= 1'b0;
      ferr      <= 1'b0;
      oerr      <= 1'b0;
      avs_readdata <= 32'h0;
      ack       <= 1'b0;
    end
    else
    begin
      st        <= next_st;
      sub       <= next_sub;
      bitn      <= next_bitn;
      shf       <= next_shf;
      ctrl      <= next_ctrl;
      div       <= next_div;
      ictrl     <= next_ictrl;
      msk       <= next_msk;
      ev        <= next_ev;
      buf_q     <= next_buf;
      buf_full  <= next_buf_full;
      ferr      <= next_ferr;
      oerr      <= next_oerr;
      avs_readdata <= next_rdata;
      ack       <= next_ack;
    end
  end

  // One wait cycle per access
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  assign any_ev = ctrl.irq_en && |(ev & msk)
                  && ictrl[asr_pkg::ICTRL_GLOBAL] && ictrl[asr_pkg::ICTRL_PERIPH];
  assign irq_high = any_ev && ictrl[asr_pkg::ICTRL_PRIO];
  assign irq_low  = any_ev && !ictrl[asr_pkg::ICTRL_PRIO];

  // no address filtering without ninth bit
  chk_addr_needs_ninth: assert property (@(posedge sys_clk) disable iff (!resetn)
    (done && !ctrl.ninth_en) |-> load) else $error("frame dropped without ninth bit");

  chk_addr_filter_drop: assert property (@(posedge sys_clk) disable iff (!resetn)
    (done && ctrl.ninth_en && ctrl.addr_det && !shf[8]) |=> $stable(buf_full) || !buf_full)
    else $error("address frame loaded with ninth bit zero");

  chk_done_sets_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    (load && !buf_full) |=> ev[asr_pkg::EV_RX_DONE] && buf_full)
    else $error("receive flag not set");

  chk_err_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ctrl.cont_en |-> !ferr && !oerr) else $error("error kept with receive disabled");

  chk_idle_disabled: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ctrl.cont_en |=> st == ST_IDLE) else $error("receiver active while disabled");

  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    (irq_high || irq_low) |-> ictrl[asr_pkg::ICTRL_GLOBAL] && ictrl[asr_pkg::ICTRL_PERIPH])
    else $error("irq without global enables");

  chk_stop_framing: assert property (@(posedge sys_clk) disable iff (!resetn)
    (load && !buf_full && !serial_receive_pin && ctrl.cont_en) |=> ferr)
    else $error("framing error missed");

  chk_port_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ctrl.clocked || !ctrl.port_en) |=> st == ST_IDLE) else $error("receiver active in clocked mode");

  chk_bit_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st == ST_DATA) |-> bitn < nbits) else $error("bit count beyond frame length");

  chk_data_pop: assert property (@(posedge sys_clk) disable iff (!resetn)
    (avs_read && !avs_waitrequest && avs_address == asr_pkg::ADDR_DATA && !load) |=> !buf_full)
    else $error("data read did not pop");

  chk_overrun_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
    (load && buf_full && !pop) |=> oerr && ev[asr_pkg::EV_OVERRUN] && $stable(buf_q))
    else $error("overrun frame not dropped");
endmodule

// [verif/asr_line_model.sv]
`timescale 1ns/1ps
module asr_line_model
#(
  parameter int BIT_CLKS = 32
)
(
  input  wire logic sys_clk,
  output logic      line
);
  initial line = 1'b1;
  task automatic send(input logic [8:0] d, input int nbits, input logic stop_ok);
    logic b;
    for (int i = 0; i < nbits + 2; i++)
    begin
      b = (i == 0) ? 1'b0 : (i <= nbits) ? d[i-1] : stop_ok;
      @(posedge sys_clk);
      line <= b;
      repeat (BIT_CLKS - 1) @(posedge sys_clk);
    end
    // Pulled-up line returns high after the frame
    @(posedge sys_clk);
    line <= 1'b1;
  endtask
endmodule

// [verif/asr_receiver_bench.sv]
`timescale 1ns/1ps
module asr_receiver_bench;
  localparam logic [7:0] PE = 8'h01 << asr_pkg::CTRL_PORT_EN;
  localparam logic [7:0] NE = 8'h01 << asr_pkg::CTRL_NINTH_EN;
  localparam logic [7:0] CK = 8'h01 << asr_pkg::CTRL_CLOCKED;
  localparam logic [7:0] CE = 8'h01 << asr_pkg::CTRL_CONT_EN;
  localparam logic [7:0] AD = 8'h01 << asr_pkg::CTRL_ADDR_DET;
  localparam logic [7:0] HS = 8'h01 << asr_pkg::CTRL_HISPEED;
  localparam logic [7:0] WD = 8'h01 << asr_pkg::CTRL_WIDE_DIV;
  localparam logic [7:0] BASE = PE | CE | (8'h01 << asr_pkg::CTRL_HISPEED) | 8'h01;
  logic        sys_clk;
  logic        resetn;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        serial_receive_pin;
  logic        irq_high;
  logic        irq_low;
  int          err_total;
  int          checks_done;
  logic [31:0] rd;
  logic [8:0]  d;
  int          exp_q[$];

  asr_receiver u_asr_receiver (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_receive_pin(serial_receive_pin), .irq_high(irq_high),
    .irq_low(irq_low));
  // Divisor 1 with high speed: tick every 2 clocks, 32 clocks a bit
  asr_line_model #(.BIT_CLKS(32)) u_line (.sys_clk(sys_clk), .line(serial_receive_pin));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20)
    begin
      err_total++;
      give_verdict();
    end
  endtask

  // Send a frame, poll sticky events, model keeps bytes loaded with a good stop bit
  task automatic rx(input logic [8:0] v, input int nb, input logic stop_ok, input logic load);
    u_line.send(v, nb, stop_ok);
    rd = 32'h0;
    for (int n = 0; n < 40 && rd[2:0] == 3'h0; n++)
      bus(0, asr_pkg::ADDR_IRQ_ST, 0);
    if (load && stop_ok)
      exp_q.push_back(v[7:0]);
    chk(rd[asr_pkg::EV_RX_DONE], load, "frame load");
  endtask

  task automatic pop_check(input logic ninth);
    bus(0, asr_pkg::ADDR_STATUS, 0);
    chk(rd[asr_pkg::STAT_NINTH], ninth, "ninth bit");
    bus(0, asr_pkg::ADDR_DATA, 0);
    chk(rd[7:0], exp_q.pop_front(), "data");
    bus(1, asr_pkg::ADDR_IRQ_ST, 32'h7);
    bus(0, asr_pkg::ADDR_IRQ_ST, 0);
    chk(rd, 32'h0, "w1c clear");
  endtask

  initial
  begin
    resetn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    checks_done = 0;
    rd = 32'h0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    void'($urandom(32'hc1bf8372));
    for (int a = 0; a < 8; a++)
    begin
      bus(0, 5'(a * 4), 0);
      chk(rd, 32'h0, "reset value");
    end
    bus(1, 5'h1e, 32'hff);
    bus(0, 5'h1e, 0);
    chk(rd, 32'h0, "unmapped read");
    $display("Test registers done");
    bus(1, asr_pkg::ADDR_DIV_LO, 32'h1);
    bus(1, asr_pkg::ADDR_DIV_HI, 32'h0);
    bus(0, asr_pkg::ADDR_DIV_LO, 0);
    chk(rd, 32'h1, "divisor");
    bus(1, asr_pkg::ADDR_IRQ_MSK, 32'h1);
    bus(1, asr_pkg::ADDR_CTRL, BASE);
    // Eight- and nine-bit frames, random payload
    for (int m = 0; m < 2; m++)
    begin
      bus(1, asr_pkg::ADDR_CTRL, m ? (BASE | NE) : BASE);
      for (int k = 0; k < 3; k++)
      begin
        d = 9'($urandom);
        rx(d, m ? 9 : 8, 1'b1, 1'b1);
        for (int g = 0; g < 8; g++)
        begin
          bus(1, asr_pkg::ADDR_ICTRL, {g[2], g[1], 5'h0, g[0]});
          @(posedge sys_clk);
          chk({irq_high, irq_low}, {g[2] & g[1] & g[0], g[2] & g[1] & !g[0]}, "irq route");
        end
        pop_check(m ? d[8] : 1'b0);
        chk({irq_high, irq_low}, 2'b00, "irq gone");
      end
      $display("Test width %0d done", m ? 9 : 8);
    end
    // Buffer left full: next frame dropped and flagged as overrun
    bus(1, asr_pkg::ADDR_CTRL, BASE);
    rx(9'h069, 8, 1'b1, 1'b1);
    bus(1, asr_pkg::ADDR_IRQ_ST, 32'h7);
    rx(9'h096, 8, 1'b1, 1'b0);
    chk(rd[asr_pkg::EV_OVERRUN], 1'b1, "overrun event");
    bus(0, asr_pkg::ADDR_STATUS, 0);
    chk(rd[asr_pkg::STAT_OVERRUN], 1'b1, "overrun seen");
    pop_check(1'b0);
    $display("Test overrun done");
    // Bad stop bit, frame still loaded, then cleared by dropping continuous receive
    rx(9'h0a5, 8, 1'b0, 1'b1);
    bus(0, asr_pkg::ADDR_STATUS, 0);
    chk(rd[asr_pkg::STAT_FRAMING], 1'b1, "framing seen");
    bus(1, asr_pkg::ADDR_CTRL, BASE & ~CE);
    bus(0, asr_pkg::ADDR_STATUS, 0);
    chk(rd[asr_pkg::STAT_FRAMING], 1'b0, "framing cleared");
    bus(0, asr_pkg::ADDR_DATA, 0);
    bus(1, asr_pkg::ADDR_IRQ_ST, 32'h7);
    rd = 32'h0;
    // Receive disabled, clocked mode or port off: frame ignored
    rx(9'h03c, 8, 1'b1, 1'b0);
    bus(1, asr_pkg::ADDR_CTRL, BASE | CK);
    rx(9'h0c3, 8, 1'b1, 1'b0);
    bus(1, asr_pkg::ADDR_CTRL, BASE & ~PE);
    rx(9'h05a, 8, 1'b1, 1'b0);
    $display("Test disabled done");
    // Address detect: ninth bit zero dropped, one loaded
    bus(1, asr_pkg::ADDR_CTRL, BASE | NE | AD);
    rx(9'h011, 9, 1'b1, 1'b0);
    rx(9'h122, 9, 1'b1, 1'b1);
    pop_check(1'b1);
    bus(1, asr_pkg::ADDR_CTRL, BASE | NE);
    rx(9'h033, 9, 1'b1, 1'b1);
    pop_check(1'b0);
    $display("Test address detect done");
    // Wide divisor at both speeds, two clocks a tick each
    for (int s = 0; s < 2; s++)
    begin
      bus(1, asr_pkg::ADDR_DIV_LO, s ? 32'h4 : 32'h1);
      bus(1, asr_pkg::ADDR_CTRL, s ? (BASE | WD) : ((BASE | WD) & ~HS));
      d = 9'($urandom);
      rx(d, 8, 1'b1, 1'b1);
      pop_check(1'b0);
    end
    $display("Test wide divisor done");
    give_verdict();
  end
endmodule
